// File: src/mbc_pkg.sv
// Shared constants and types of the memory bus controller
// Notes on behaviour
// [RULE_01] All transfers are little-endian; masters issue little-endian accesses only.
// [RULE_02] Fixed priority grant: Ethernet master first, DMA next, processor last.
// [RULE_03] Top four address bits pick internal, peripheral or one of fourteen abort regions.
// [RULE_04] Eight more bits split the internal region into 1-Mbyte memory slots.
// [RULE_05] A small memory repeats through its whole slot, ignoring bits above its size.
// [RULE_06] An unassigned internal-region address returns an abort to the requester.
// [RULE_07] Internal addresses 0x0040_0000 to 0x0FFF_FFFF are undefined and abort.
// [RULE_08] Boot slot shows flash without remap, SRAM with it; originals stay reachable.
// [RULE_09] Writing 1 to remap control bit 0 inverts remap; 0 has no effect.
// [RULE_10] Reset clears remap so flash sits in the boot slot.
// [RULE_11] Any abort is signalled to all masters at once.
// [RULE_12] Only the processor acts on abort, and only for its own access.
// [RULE_13] Each abort stores the full 32-bit failing address.
// [RULE_14] Each abort records the transfer size of the failing access.
// [RULE_15] Each abort records data read, data write or instruction fetch.
// [RULE_16] Each abort sets exactly one cause: undefined or misaligned address.
// [RULE_17] Each abort sets one last-source flag and clears the other two.
// [RULE_18] Sticky per-master flags record unshown aborts; status read clears them.
// [RULE_19] A processor data abort stores the data address, not the instruction address.
// [RULE_20] Misaligned word or half-word access from any master aborts and is cancelled.
// [RULE_21] Processor instruction fetches skip the alignment check.
// [RULE_22] Size field codes: 00 byte, 01 half-word, 10 word, 11 reserved.
// [RULE_23] Type field codes: 00 read, 01 write, 10 fetch, 11 reserved.
// [RULE_24] Slot 1 holds the flash, slot 2 the SRAM.
// [RULE_25] Each new abort overwrites address, size, type, cause and last source.
// [RULE_26] Lower masters wait for higher ones; a transfer completes before regrant.
package mbc_pkg;

	localparam int NUM_MASTERS = 3;

	// Master indices, lower index wins
	localparam logic [1:0] MST_ETH = 2'h0;
	localparam logic [1:0] MST_DMA = 2'h1;
	localparam logic [1:0] MST_CPU = 2'h2;

	// APB register byte offsets
	localparam logic [7:0] OFS_REMAP_CONTROL = 8'h00;
	localparam logic [7:0] OFS_ABORT_STATUS  = 8'h04;
	localparam logic [7:0] OFS_ABORT_ADDRESS = 8'h08;

	localparam int REMAP_TOGGLE_BIT = 0;

	// Abort status field positions
	localparam int ASR_UNDEFINED_POS = 0;
	localparam int ASR_MISALIGNED_POS = 1;
	localparam int ASR_SIZE_LSB = 8;
	localparam int ASR_TYPE_LSB = 10;
	localparam int ASR_LAST_SRC_LSB = 16;
	localparam int ASR_STICKY_LSB = 24;

	localparam logic [31:0] RESET_ABORT_STATUS = 32'h0000_0000;
	localparam logic [31:0] RESET_ABORT_ADDRESS = 32'h0000_0000;

	// Transfer size codes
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// Access type codes
	localparam logic [1:0] TYPE_READ = 2'h0;
	localparam logic [1:0] TYPE_WRITE = 2'h1;
	localparam logic [1:0] TYPE_FETCH = 2'h2;

	// Address decode
	localparam logic [3:0] REGION_INTERNAL = 4'h0;
	localparam logic [3:0] REGION_PERIPH = 4'hf;
	localparam logic [7:0] SLOT_BOOT = 8'h00;
	localparam logic [7:0] SLOT_FLASH = 8'h01;
	localparam logic [7:0] SLOT_SRAM = 8'h02;
	localparam logic [7:0] SLOT_ROM = 8'h03;
	localparam int SLOT_OFS_W = 20;

	// Target codes driven on the memory side
	localparam logic [1:0] TGT_FLASH = 2'h0;
	localparam logic [1:0] TGT_SRAM = 2'h1;
	localparam logic [1:0] TGT_ROM = 2'h2;
	localparam logic [1:0] TGT_PERIPH = 2'h3;

	typedef enum logic [1:0] {
		MBC_IDLE,
		MBC_XFER,
		MBC_DONE
	} mbc_state_t;

endpackage

// File: src/mbc_top.sv
// Memory bus controller: arbiter, decoder, remap, alignment check, abort capture
`timescale 1ns/1ns
module mbc_top
	import mbc_pkg::*;
#(
	parameter int FLASH_AW = 18,
	parameter int SRAM_AW  = 16,
	parameter int ROM_AW   = 14
) (
	input  wire logic                        clk_sys,
	input  wire logic                        rstn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Masters: index 0 Ethernet, 1 DMA, 2 processor
	input  wire logic [NUM_MASTERS-1:0]        m_req,
	input  wire logic [NUM_MASTERS-1:0][31:0]  m_addr,
	input  wire logic [NUM_MASTERS-1:0][1:0]   m_size,
	input  wire logic [NUM_MASTERS-1:0][1:0]   m_type,
	input  wire logic [NUM_MASTERS-1:0][31:0]  m_wdata,
	output logic [NUM_MASTERS-1:0]             m_grant,
	output logic [NUM_MASTERS-1:0]             m_done,
	output logic                             bus_abort,
	output logic [31:0]                      bus_rdata,
	// Memory and peripheral side
	output logic                             mem_valid,
	output logic [1:0]                       mem_target,
	output logic [27:0]                      mem_addr,
	output logic                             mem_write,
	output logic [3:0]                       mem_be,
	output logic [31:0]                      mem_wdata,
	input  wire logic                        mem_ready,
	input  wire logic [31:0]                 mem_rdata,
	output logic                             remap_state
);

	mbc_state_t                state_ff;
	mbc_state_t                nxt_state;
	logic [1:0]                gnt_ff;
	logic [1:0]                nxt_gnt;
	logic [31:0]               req_addr_ff;
	logic [1:0]                req_size_ff;
	logic [1:0]                req_type_ff;
	logic [31:0]               req_wdata_ff;
	logic                      done_ff;
	logic                      abort_ff;
	logic [31:0]               rdata_ff;
	logic                      remap_ff;
	logic [31:0]               abort_addr_ff;
	logic [1:0]                abort_size_ff;
	logic [1:0]                abort_type_ff;
	logic                      undefined_flag_ff;
	logic                      misaligned_flag_ff;
	logic [NUM_MASTERS-1:0]    last_src_ff;
	logic [NUM_MASTERS-1:0]    sticky_src_ff;
	logic                      last_unread_ff;
	logic [31:0]               prdata_ff;
	logic                      snap_late_ff;

	logic                      any_req;
	logic                      dec_undefined;
	logic                      dec_misaligned;
	logic                      dec_abort;
	logic [1:0]                dec_target;
	logic [27:0]               dec_addr;
	logic                      xfer_end;
	logic                      apb_access;
	logic                      apb_setup;
	logic                      apb_mapped;
	logic                      status_read;
	logic [NUM_MASTERS-1:0]    gnt_onehot;
	logic [31:0]               status_word;

	// Offset inside a memory of 2**aw bytes; upper bits fold away so it repeats in the slot
	function automatic logic [27:0] wrap_offset(input logic [31:0] a, input int aw);
		logic [27:0] mask;
		mask = (28'h000_0001 << aw) - 28'h000_0001;
		return {8'h00, a[SLOT_OFS_W-1:0]} & mask; // RULE_05
	endfunction

	// Byte enables, byte 0 on the lowest lane
	function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic [1:0] sz);
		logic [3:0] m;
		m = 4'h1;
		if (sz == SIZE_HALF) begin
			m = 4'h3;
		end else if (sz == SIZE_WORD) begin
			m = 4'hf;
		end
		return 4'((m << a) & 4'hf); // RULE_01
	endfunction

	function automatic logic [NUM_MASTERS-1:0] onehot(input logic [1:0] idx);
		return NUM_MASTERS'(1) << idx;
	endfunction

	// Fixed priority: lowest index with a request wins
	always_comb begin
		any_req = |m_req;
		nxt_gnt = MST_CPU;
		if (m_req[MST_ETH]) begin // RULE_02
			nxt_gnt = MST_ETH;
		end else if (m_req[MST_DMA]) begin
			nxt_gnt = MST_DMA;
		end
	end

	// Decode of the latched request
	always_comb begin
		dec_undefined = 1'b0;
		dec_target = TGT_PERIPH;
		dec_addr = req_addr_ff[27:0];
		unique case (req_addr_ff[31:28]) // RULE_03
			REGION_INTERNAL: begin
				unique case (req_addr_ff[27:20]) // RULE_04
					SLOT_BOOT: begin
						dec_target = remap_ff ? TGT_SRAM : TGT_FLASH; // RULE_08
						dec_addr = remap_ff ? wrap_offset(req_addr_ff, SRAM_AW)
							: wrap_offset(req_addr_ff, FLASH_AW);
					end
					SLOT_FLASH: begin
						dec_target = TGT_FLASH; // RULE_24
						dec_addr = wrap_offset(req_addr_ff, FLASH_AW);
					end
					SLOT_SRAM: begin
						dec_target = TGT_SRAM; // RULE_24
						dec_addr = wrap_offset(req_addr_ff, SRAM_AW);
					end
					SLOT_ROM: begin
						dec_target = TGT_ROM;
						dec_addr = wrap_offset(req_addr_ff, ROM_AW);
					end
					default: begin
						dec_undefined = 1'b1; // RULE_06 RULE_07
					end
				endcase
			end
			REGION_PERIPH: begin
				dec_target = TGT_PERIPH;
			end
			default: begin
				dec_undefined = 1'b1; // RULE_03
			end
		endcase
	end

	// Only processor fetches skip the check; other masters are checked whatever they claim
	always_comb begin
		dec_misaligned = 1'b0;
		if (req_type_ff != TYPE_FETCH || gnt_ff != MST_CPU) begin // RULE_21
			if (req_size_ff == SIZE_WORD) begin
				dec_misaligned = req_addr_ff[1:0] != 2'h0; // RULE_20
			end else if (req_size_ff == SIZE_HALF) begin
				dec_misaligned = req_addr_ff[0]; // RULE_20
			end
		end
		dec_abort = dec_undefined | dec_misaligned;
	end

	// An aborted access ends at once and never reaches a memory
	assign xfer_end = (state_ff == MBC_XFER) && (dec_abort || mem_ready);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			MBC_IDLE: begin
				if (any_req) begin
					nxt_state = MBC_XFER;
				end
			end
			MBC_XFER: begin
				if (xfer_end) begin // RULE_26
					nxt_state = MBC_DONE;
				end
			end
			MBC_DONE: begin
				nxt_state = MBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= MBC_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Grant and request are frozen until the transfer finishes
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			gnt_ff <= MST_CPU;
			req_addr_ff <= 32'h0000_0000;
			req_size_ff <= SIZE_BYTE;
			req_type_ff <= TYPE_READ;
			req_wdata_ff <= 32'h0000_0000;
		end else if (state_ff == MBC_IDLE && any_req) begin
			gnt_ff <= nxt_gnt; // RULE_26
			req_addr_ff <= m_addr[nxt_gnt];
			req_size_ff <= m_size[nxt_gnt];
			req_type_ff <= m_type[nxt_gnt];
			req_wdata_ff <= m_wdata[nxt_gnt];
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			done_ff <= xfer_end;
			abort_ff <= xfer_end && dec_abort; // RULE_11
			if (xfer_end && !dec_abort) begin
				rdata_ff <= mem_rdata;
			end
		end
	end

	assign gnt_onehot = onehot(gnt_ff);
	assign m_grant = (state_ff == MBC_IDLE) ? '0 : gnt_onehot;
	assign m_done = done_ff ? gnt_onehot : '0;
	// Every master sees the abort; only the processor is expected to act on it
	assign bus_abort = abort_ff; // RULE_11 RULE_12
	assign bus_rdata = rdata_ff;

	assign mem_valid = (state_ff == MBC_XFER) && !dec_abort; // RULE_20
	assign mem_target = dec_target;
	assign mem_addr = dec_addr;
	assign mem_write = req_type_ff == TYPE_WRITE;
	assign mem_be = lane_mask(req_addr_ff[1:0], req_size_ff);
	assign mem_wdata = req_wdata_ff;

	// Abort capture; the latched address is the data address itself
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			abort_addr_ff <= RESET_ABORT_ADDRESS;
			abort_size_ff <= SIZE_BYTE;
			abort_type_ff <= TYPE_READ;
			undefined_flag_ff <= 1'b0;
			misaligned_flag_ff <= 1'b0;
			last_src_ff <= '0;
		end else if (xfer_end && dec_abort) begin // RULE_25
			abort_addr_ff <= req_addr_ff; // RULE_13 RULE_19
			abort_size_ff <= req_size_ff; // RULE_14 RULE_22
			abort_type_ff <= req_type_ff; // RULE_15 RULE_23
			undefined_flag_ff <= dec_undefined; // RULE_16
			misaligned_flag_ff <= !dec_undefined; // RULE_16
			last_src_ff <= gnt_onehot; // RULE_17
		end
	end

	// A displaced, unread last source moves into the sticky flags; this set beats the read clear
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sticky_src_ff <= '0;
			last_unread_ff <= 1'b0;
		end else begin
			if (xfer_end && dec_abort) begin
				sticky_src_ff <= (status_read ? '0 : sticky_src_ff)
					| (last_unread_ff ? last_src_ff : '0); // RULE_18
				last_unread_ff <= 1'b1;
			end else if (status_read) begin
				sticky_src_ff <= '0; // RULE_18
				last_unread_ff <= snap_late_ff; // RULE_18
			end
		end
	end

	// APB: zero wait states, error on unmapped offsets
	assign apb_setup = psel && !penable;
	assign apb_access = psel && penable;
	assign apb_mapped = (paddr == OFS_REMAP_CONTROL) || (paddr == OFS_ABORT_STATUS)
		|| (paddr == OFS_ABORT_ADDRESS);
	assign status_read = apb_access && !pwrite && (paddr == OFS_ABORT_STATUS);
	assign pready = 1'b1;
	assign pslverr = apb_access && !apb_mapped;
	assign prdata = prdata_ff;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			remap_ff <= 1'b0; // RULE_10
		end else if (apb_access && pwrite && paddr == OFS_REMAP_CONTROL
			&& pwdata[REMAP_TOGGLE_BIT]) begin
			remap_ff <= !remap_ff; // RULE_09
		end
	end

	assign remap_state = remap_ff;

	// Status word as software reads it
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ASR_UNDEFINED_POS] = undefined_flag_ff;
		status_word[ASR_MISALIGNED_POS] = misaligned_flag_ff;
		status_word[ASR_SIZE_LSB +: 2] = abort_size_ff;
		status_word[ASR_TYPE_LSB +: 2] = abort_type_ff;
		status_word[ASR_LAST_SRC_LSB +: NUM_MASTERS] = last_src_ff;
		status_word[ASR_STICKY_LSB +: NUM_MASTERS] = sticky_src_ff;
	end

	// Read data is staged in the setup phase so the access phase needs no wait
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata_ff <= 32'h0000_0000;
			if (!pwrite && paddr == OFS_ABORT_STATUS) begin
				prdata_ff <= status_word;
			end else if (!pwrite && paddr == OFS_ABORT_ADDRESS) begin
				prdata_ff <= abort_addr_ff;
			end
		end
	end

	// An abort landing on the setup edge of a status read is missing from the staged word,
	// so the access that clears the flags must not count it as shown
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			snap_late_ff <= 1'b0;
		end else if (apb_setup) begin
			snap_late_ff <= xfer_end && dec_abort; // RULE_18
		end
	end

endmodule // mbc_top

// File: bench/mbc_checker.sv
// Port-level assertions of the memory bus controller
`timescale 1ns/1ns
module mbc_checker
	import mbc_pkg::*;
(
	input wire logic	clk_sys,
	input wire logic	rstn,
	input wire logic	psel,
	input wire logic	penable,
	input wire logic	pwrite,
	input wire logic [7:0]	paddr,
	input wire logic [31:0]	pwdata,
	input wire logic [NUM_MASTERS-1:0]	m_req,
	input wire logic [NUM_MASTERS-1:0][31:0]	m_addr,
	input wire logic [NUM_MASTERS-1:0][1:0]	m_size,
	input wire logic [NUM_MASTERS-1:0]	m_grant,
	input wire logic [NUM_MASTERS-1:0]	m_done,
	input wire logic	bus_abort,
	input wire logic	mem_valid,
	input wire logic	remap_state
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire	idle = (m_grant == 3'h0);
	sequence eth_take;
		idle && m_req[0];
	endsequence
	sequence abort_out;
		##2 (bus_abort && m_done[0]);
	endsequence
	eth_first_a: assert property (eth_take |=> m_grant == 3'h1)
		else $error("ethernet master not granted first");
	dma_next_a: assert property (idle && m_req == 3'h6 |=> m_grant == 3'h2)
		else $error("dma master not granted over processor");
	grant_hold_a: assert property (!idle && m_done == 3'h0 |=> $stable(m_grant))
		else $error("grant changed during a transfer");
	abort_all_a: assert property (bus_abort |-> m_done == m_grant && !idle)
		else $error("abort without completion to owner");
	region_abort_a: assert property (eth_take ##0 m_addr[0][31:28] inside {[4'h1:4'he]}
		|-> abort_out)
		else $error("undefined region did not abort");
	hole_abort_a: assert property (eth_take ##0 (m_addr[0][31:28] == 4'h0
		&& m_addr[0][27:22] != 6'h0) |-> abort_out)
		else $error("internal hole did not abort");
	misalign_abort_a: assert property (eth_take ##0 (m_size[0] == SIZE_WORD && m_addr[0][1:0] != 2'h0
		|| m_size[0] == SIZE_HALF && m_addr[0][0]) |-> abort_out)
		else $error("misaligned access did not abort");
	access_cancel_a: assert property (bus_abort |-> !$past(mem_valid) && !mem_valid)
		else $error("aborted access reached memory");
	remap_flip_a: assert property (psel && penable && pwrite && paddr == OFS_REMAP_CONTROL
		|=> (remap_state != $past(remap_state)) == $past(pwdata[0]))
		else $error("remap did not follow toggle bit");
endmodule // mbc_checker
bind mbc_top mbc_checker chk_i (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.m_req, .m_addr, .m_size, .m_grant, .m_done, .bus_abort, .mem_valid, .remap_state);

// File: bench/mbc_mem_model.sv
// Memory and peripheral target model that answers fast or with wait cycles
`timescale 1ns/1ns
module mbc_mem_model (
	input wire logic	clk_sys,
	input wire logic	rstn,
	input wire logic	slow,
	input wire logic	mem_valid,
	input wire logic [1:0]	mem_target,
	input wire logic [27:0]	mem_addr,
	output logic	mem_ready,
	output logic [31:0]	mem_rdata
);
	logic [1:0]	wait_ff;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wait_ff <= 2'h0;
		end else if (mem_valid && !mem_ready) begin
			wait_ff <= wait_ff + 2'h1;
		end else begin
			wait_ff <= 2'h0;
		end
	end
	assign mem_ready = mem_valid && (!slow || wait_ff == 2'h2);
	// Data names the target and offset; inverted outside the answer so stale data shows
	assign mem_rdata = mem_ready ? {2'h0, mem_target, mem_addr} : ~{2'h0, mem_target, mem_addr};
endmodule // mbc_mem_model

// File: bench/mbc_bench.sv
// Self-checking bench of the memory bus controller
`timescale 1ns/1ns
module mbc_bench
	import mbc_pkg::*;
;
	logic	clk_sys, rstn, psel, penable, pwrite, slow, mem_ready;
	logic	pready, pslverr, bus_abort, mem_valid, mem_write, remap_state;
	logic [7:0]	paddr;
	logic [31:0]	pwdata, prdata, bus_rdata, mem_rdata, mem_wdata;
	logic [2:0]	m_req, m_grant, m_done;
	logic [2:0][31:0]	m_addr, m_wdata;
	logic [2:0][1:0]	m_size, m_type;
	logic [1:0]	mem_target;
	logic [27:0]	mem_addr;
	logic [3:0]	mem_be;
	int	failures, checks;
	mbc_top #(.FLASH_AW(18), .SRAM_AW(16), .ROM_AW(14)) uut (.clk_sys, .rstn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .m_req, .m_addr, .m_size, .m_type,
		.m_wdata, .m_grant, .m_done, .bus_abort, .bus_rdata, .mem_valid, .mem_target, .mem_addr,
		.mem_write, .mem_be, .mem_wdata, .mem_ready, .mem_rdata, .remap_state);
	mbc_mem_model mem_i (.clk_sys, .rstn, .slow, .mem_valid, .mem_target, .mem_addr, .mem_ready,
		.mem_rdata);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic give_verdict;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] ex(input logic [1:0] t, input logic [31:0] a, input int aw);
		logic [31:0] o;
		o = a & ((32'h1 << aw) - 32'h1);
		return {2'h0, t, o[27:0]};
	endfunction
	function automatic logic [31:0] st(input logic mis, input logic [1:0] sz, tp, m,
		input logic [2:0] sk);
		logic [31:0] v;
		v = 32'h0;
		v[mis ? ASR_MISALIGNED_POS : ASR_UNDEFINED_POS] = 1'b1;
		v[ASR_SIZE_LSB +: 2] = sz;
		v[ASR_TYPE_LSB +: 2] = tp;
		v[ASR_LAST_SRC_LSB + m] = 1'b1;
		v[ASR_STICKY_LSB +: 3] = sk;
		return v;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) failures++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic xfer(input logic [1:0] m, input logic [31:0] a, input logic [1:0] sz, tp,
		output logic [31:0] r, output logic ab, output logic [3:0] be);
		int n;
		@(posedge clk_sys);
		m_req[m] <= 1'b1;
		m_addr[m] <= a;
		m_size[m] <= sz;
		m_type[m] <= tp;
		m_wdata[m] <= ~a;
		n = 0;
		be = 4'h0;
		do begin
			@(negedge clk_sys);
			if (mem_valid === 1'b1) begin
				be = mem_be;
				chk({31'h0, mem_write}, {31'h0, tp == TYPE_WRITE});
				chk(mem_wdata, ~a);
			end
			n++;
		end while (m_done[m] !== 1'b1 && n < 40);
		chk({31'h0, m_done[m]}, 32'h1);
		r = bus_rdata;
		ab = bus_abort;
		@(posedge clk_sys);
		m_req[m] <= 1'b0;
	endtask
	task automatic rd1(input logic [1:0] m, input logic [31:0] a, input logic [1:0] tp,
		input logic [31:0] exp);
		logic [31:0] r;
		logic ab;
		logic [3:0] be;
		xfer(m, a, SIZE_WORD, tp, r, ab, be);
		chk({31'h0, ab}, 32'h0);
		chk(r, exp);
	endtask
	task automatic ab1(input logic [1:0] m, input logic [31:0] a, input logic [1:0] sz, tp,
		input logic mis);
		logic [31:0] r;
		logic ab, e;
		logic [3:0] be;
		xfer(m, a, sz, tp, r, ab, be);
		chk({31'h0, ab}, 32'h1);
		apb(1'b0, OFS_ABORT_ADDRESS, 32'h0, r, e);
		chk(r, a);
		apb(1'b0, OFS_ABORT_STATUS, 32'h0, r, e);
		chk(r, st(mis, sz, tp, m, 3'h0));
	endtask
	task automatic t_reset;
		logic [31:0] r;
		logic e;
		chk({31'h0, remap_state}, 32'h0);
		apb(1'b0, OFS_ABORT_STATUS, 32'h0, r, e);
		chk(r, RESET_ABORT_STATUS);
		apb(1'b1, OFS_ABORT_ADDRESS, 32'hffff_ffff, r, e);
		apb(1'b0, OFS_ABORT_ADDRESS, 32'h0, r, e);
		chk(r, RESET_ABORT_ADDRESS);
		apb(1'b0, 8'h0c, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		$display("test reset done");
	endtask
	task automatic t_decode;
		logic [31:0] r;
		logic ab;
		logic [3:0] be;
		rd1(MST_CPU, 32'h0010_0040, TYPE_READ, ex(TGT_FLASH, 32'h40, 18));
		rd1(MST_DMA, 32'h001f_fffc, TYPE_READ, ex(TGT_FLASH, 32'h001f_fffc, 18));
		rd1(MST_ETH, 32'h0021_1234, TYPE_READ, ex(TGT_SRAM, 32'h1234, 16));
		rd1(MST_CPU, 32'h003f_fffc, TYPE_READ, ex(TGT_ROM, 32'h003f_fffc, 14));
		rd1(MST_CPU, 32'h0000_0040, TYPE_READ, ex(TGT_FLASH, 32'h40, 18));
		rd1(MST_CPU, 32'hf001_2344, TYPE_READ, ex(TGT_PERIPH, 32'hf001_2344, 28));
		rd1(MST_CPU, 32'h0020_0002, TYPE_FETCH, ex(TGT_SRAM, 32'h2, 16));
		xfer(MST_DMA, 32'h0020_0012, SIZE_BYTE, TYPE_WRITE, r, ab, be);
		chk({28'h0, be}, 32'h4);
		$display("test decode done");
	endtask
	task automatic t_remap;
		logic [31:0] r;
		logic e;
		apb(1'b1, OFS_REMAP_CONTROL, 32'h1, r, e);
		chk({31'h0, remap_state}, 32'h1);
		rd1(MST_CPU, 32'h0000_0040, TYPE_READ, ex(TGT_SRAM, 32'h40, 16));
		rd1(MST_CPU, 32'h0010_0040, TYPE_READ, ex(TGT_FLASH, 32'h40, 18));
		apb(1'b1, OFS_REMAP_CONTROL, 32'hffff_fffe, r, e);
		chk({31'h0, remap_state}, 32'h1);
		apb(1'b0, OFS_REMAP_CONTROL, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b1, OFS_REMAP_CONTROL, 32'h1, r, e);
		chk({31'h0, remap_state}, 32'h0);
		rd1(MST_CPU, 32'h0000_0040, TYPE_READ, ex(TGT_FLASH, 32'h40, 18));
		$display("test remap done");
	endtask
	task automatic t_abort;
		ab1(MST_ETH, 32'h1000_0000, SIZE_BYTE, TYPE_READ, 1'b0);
		ab1(MST_DMA, 32'h0040_0004, SIZE_WORD, TYPE_WRITE, 1'b0);
		ab1(MST_CPU, 32'h0020_0001, SIZE_HALF, TYPE_READ, 1'b1);
		ab1(MST_ETH, 32'h0020_0006, SIZE_WORD, TYPE_WRITE, 1'b1);
		ab1(MST_CPU, 32'he000_0002, SIZE_WORD, TYPE_FETCH, 1'b0);
		ab1(MST_ETH, 32'h0fff_fffe, SIZE_HALF, TYPE_READ, 1'b0);
		$display("test abort done");
	endtask
	task automatic t_sticky;
		logic [31:0] r;
		logic ab, e;
		logic [3:0] be;
		xfer(MST_ETH, 32'h2000_0000, SIZE_WORD, TYPE_WRITE, r, ab, be);
		xfer(MST_CPU, 32'h0020_0003, SIZE_WORD, TYPE_READ, r, ab, be);
		apb(1'b0, OFS_ABORT_STATUS, 32'h0, r, e);
		chk(r, st(1'b1, SIZE_WORD, TYPE_READ, MST_CPU, 3'h1));
		apb(1'b0, OFS_ABORT_STATUS, 32'h0, r, e);
		chk(r, st(1'b1, SIZE_WORD, TYPE_READ, MST_CPU, 3'h0));
		apb(1'b0, OFS_ABORT_ADDRESS, 32'h0, r, e);
		chk(r, 32'h0020_0003);
		$display("test sticky done");
	endtask
	task automatic t_prio;
		int k, n;
		@(posedge clk_sys);
		slow <= 1'b1;
		for (k = 0; k < 3; k++) begin
			m_addr[k] <= 32'h0020_0100 + k * 4;
			m_size[k] <= SIZE_WORD;
			m_type[k] <= TYPE_READ;
		end
		m_req <= 3'h7;
		for (k = 0; k < 3; k++) begin
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (m_done === 3'h0 && n < 40);
			chk({29'h0, m_done}, 32'h1 << k);
			chk(bus_rdata, ex(TGT_SRAM, 32'h100 + k * 4, 16));
			@(posedge clk_sys);
			m_req[k] <= 1'b0;
		end
		slow <= 1'b0;
		$display("test priority done");
	endtask
	initial begin
		rstn = 1'b0;
		{psel, penable, pwrite, slow, paddr, pwdata} = '0;
		{m_req, m_addr, m_size, m_type, m_wdata} = '0;
		failures = 0;
		checks = 0;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		t_reset();
		t_decode();
		t_remap();
		t_abort();
		t_sticky();
		t_prio();
		give_verdict();
	end
	// Tests need well under a thousand cycles; ten thousand means a hang
	initial begin
		#100000;
		failures++;
		give_verdict();
	end
endmodule // mbc_bench
